// ---- rtl/adcpo_buf2.sv ----
// two entry elastic buffer with valid and ready on both sides
`timescale 1ns/10ps
module adcpo_buf2
   import adcpo_pkg::*;
#(
   parameter int W = $bits(adcpo_word_s),
   parameter int DEPTH = ADCPO_BUF_DEPTH
)(
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_ff [DEPTH];
   logic [W-1:0] nxt_mem [DEPTH];
   logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [PW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready = (cnt_ff != (PW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];

   // pointer and occupancy update; both sides may move in one cycle
   always_comb begin
      push = run && in_valid && in_ready;
      pop = run && out_valid && out_ready;
      nxt_mem = mem_ff;
      nxt_wr = wr_ff;
      nxt_rd = rd_ff;
      nxt_cnt = cnt_ff;
      if (push) begin
         nxt_mem[wr_ff] = in_data;
         nxt_wr = wr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rd = rd_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_cnt = cnt_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         mem_ff <= nxt_mem;
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule : adcpo_buf2

// ---- rtl/adcpo_decim.sv ----
// integrate and dump decimator, one result per 32 modulator clocks
`timescale 1ns/10ps
module adcpo_decim
   import adcpo_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic mod_bit,
   input wire logic out_ready,
   output logic out_valid,
   output adcpo_word_s out_word
);
   logic [4:0] cnt_ff, nxt_cnt;
   logic [5:0] ones_ff, nxt_ones;
   logic valid_ff, nxt_valid;
   adcpo_word_s word_ff, nxt_word;
   logic [5:0] sum;
   logic [19:0] scaled;

   // count ones over the window; a held word is kept until taken
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_ones = ones_ff;
      nxt_valid = valid_ff;
      nxt_word = word_ff;
      sum = ones_ff + {5'h00, mod_bit};
      scaled = ((20'(sum) << 1) - ADCPO_SUM_MID) << ADCPO_SCALE_SHIFT;
      if (run) begin
         nxt_cnt = cnt_ff + 5'h01;
         nxt_ones = sum;
         if (valid_ff && out_ready) begin
            nxt_valid = 1'b0;
         end
         if (cnt_ff == ADCPO_DEC_LAST) begin
            nxt_ones = 6'h00;
            // the buffer stalls only if the reader lags two words
            if (!valid_ff || out_ready) begin
               nxt_valid = 1'b1;
               nxt_word.data = (sum == ADCPO_SUM_FULL) ? ADCPO_POS_FS
                             : scaled[ADCPO_RES_W-1:0];
               // modulator pinned at either rail means out of range
               nxt_word.ovr = (sum == ADCPO_SUM_FULL) ||
                              (sum == ADCPO_SUM_EMPTY);
            end
         end
      end
   end

   // filter state is cleared by the reset pin
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= 5'h00;
         ones_ff <= 6'h00;
         valid_ff <= 1'b0;
         word_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
         ones_ff <= nxt_ones;
         valid_ff <= nxt_valid;
         word_ff <= nxt_word;
      end
   end

   assign out_valid = valid_ff;
   assign out_word = word_ff;

   AST_DECIM_RATE: assert property (@(posedge clk)
      disable iff (!resetn)
      run && cnt_ff == ADCPO_DEC_LAST && (!valid_ff || out_ready)
      |=> valid_ff && ones_ff == 6'h00)
      else $error("result not produced at end of window");
   AST_DECIM_OVR: assert property (@(posedge clk)
      disable iff (!resetn)
      run && cnt_ff == ADCPO_DEC_LAST && !valid_ff && ones_ff == 6'h00
      && !mod_bit |=> word_ff.ovr)
      else $error("rail result did not raise over range");
endmodule : adcpo_decim

// ---- rtl/adcpo_pkg.sv ----
// constants, word carrier and state codes for the parallel output block
package adcpo_pkg;
   localparam int ADCPO_RES_W = 18;           // result width on the bus
   localparam int ADCPO_DECIM = 32;           // modulator clocks per result
   localparam int ADCPO_HALF = 16;            // ready phase length, direct
   localparam int ADCPO_SETTLE_CNT = 46;      // ready cycles before settled
   localparam int ADCPO_SCALE_SHIFT = 12;     // ones count to code scaling
   localparam int ADCPO_MEM_DEPTH = 16;       // burst store entries
   localparam int ADCPO_PTR_W = 4;
   localparam int ADCPO_BUF_DEPTH = 2;        // elastic buffer entries
   localparam logic [5:0] ADCPO_SUM_FULL = 6'h20;
   localparam logic [5:0] ADCPO_SUM_EMPTY = 6'h00;
   localparam logic [19:0] ADCPO_SUM_MID = 20'h00020;
   localparam logic [17:0] ADCPO_POS_FS = 18'h1FFFF;
   localparam logic [17:0] ADCPO_DOUT_RST = 18'h00000;
   localparam logic [4:0] ADCPO_DEC_LAST = 5'h1F;
   localparam logic [8:0] ADCPO_HALF_T = 9'h010;
   localparam logic [5:0] ADCPO_SETTLE_T = 6'h2E;
   localparam int ADCPO_LEN_SHIFT = 5;        // times 32 clocks
   localparam logic [8:0] ADCPO_SYNC_WAIT = 9'h002; // pins through syncs
   // sync vector {sel[2:0], buffer_en, powerdown_n, cs_n, rd_n}
   localparam logic [6:0] ADCPO_SYNC_RST = 7'h07;

   typedef struct packed {
      logic [ADCPO_RES_W-1:0] data;
      logic ovr;
   } adcpo_word_s;

   typedef enum logic [1:0] {
      ADCPO_ST_RESTART = 2'b00,
      ADCPO_ST_DIRECT = 2'b01,
      ADCPO_ST_FIRST = 2'b10,
      ADCPO_ST_BURST = 2'b11
   } adcpo_state_e;
endpackage : adcpo_pkg

// ---- rtl/adcpo_top.sv ----
// parallel result port: decimator, buffering, ready strobe and bus drive
`timescale 1ns/10ps
module adcpo_top
   import adcpo_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic CLK_EN,
   input wire logic MOD_BIT,
   input wire logic POWERDOWN_N,
   input wire logic BUFFER_EN,
   input wire logic [2:0] BUFFER_DEPTH_SEL,
   input wire logic RD_N,
   input wire logic CS_N,
   output logic SAMPLE_READY_N,
   output logic [ADCPO_RES_W-1:0] DOUT_O,
   output logic DOUT_OE,
   output logic OVER_RANGE_FLAG,
   output logic DATA_SETTLED
);
   // true on the last cycle of a window of len clocks
   function automatic logic adcpo_last(input logic [8:0] t,
                                       input logic [8:0] len);
      return t == (len - 9'h001);
   endfunction : adcpo_last

   // pin synchronisers, two stages each
   logic [6:0] pins, sync1_ff, sync2_ff;
   assign pins = {BUFFER_DEPTH_SEL, BUFFER_EN, POWERDOWN_N, CS_N, RD_N};
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_sync
         always_ff @(posedge CLK_SYS or negedge RESETN) begin
            if (!RESETN) begin
               sync1_ff[g] <= ADCPO_SYNC_RST[g];
               sync2_ff[g] <= ADCPO_SYNC_RST[g];
            end else if (CLK_EN) begin
               sync1_ff[g] <= pins[g];
               sync2_ff[g] <= sync1_ff[g];
            end
         end
      end
   endgenerate

   logic rd_s, cs_s, pd_s, buf_en_s;
   logic [3:0] readings_per_burst;
   logic [8:0] burst_len, first_len;
   logic run;
   assign rd_s = sync2_ff[0];
   assign cs_s = sync2_ff[1];
   assign pd_s = sync2_ff[2];
   assign buf_en_s = sync2_ff[3];
   // level code 0..7 gives 1..8 readings per burst
   assign readings_per_burst = {1'b0, sync2_ff[6:4]} + 4'h1;
   assign burst_len = 9'(readings_per_burst) << ADCPO_LEN_SHIFT;
   assign first_len = burst_len + 9'(ADCPO_DECIM);
   // power down freezes the whole datapath, like the clock enable
   assign run = CLK_EN && pd_s;

   // decimator and elastic buffer in the data path
   logic dec_valid, dec_ready, buf_valid, buf_ready;
   adcpo_word_s dec_word, buf_word;

   adcpo_decim u_decim (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .run(run),
      .mod_bit(MOD_BIT),
      .out_ready(dec_ready),
      .out_valid(dec_valid),
      .out_word(dec_word)
   );

   adcpo_buf2 u_buf (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .run(run),
      .in_valid(dec_valid),
      .in_ready(dec_ready),
      .in_data(dec_word),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_word)
   );

   // sequencing and output state
   adcpo_state_e state_ff, nxt_state;
   logic [8:0] timer_ff, nxt_timer;
   logic ready_ff, nxt_ready;
   logic [ADCPO_RES_W-1:0] dout_ff, nxt_dout;
   logic ovr_ff, nxt_ovr;
   logic oe_ff, nxt_oe;
   logic [5:0] settle_ff, nxt_settle;
   logic settled_ff, nxt_settled;
   logic rd_prev_ff, nxt_rd_prev;
   logic [3:0] avail_ff, nxt_avail;
   adcpo_word_s mem_ff [ADCPO_MEM_DEPTH];
   adcpo_word_s nxt_mem [ADCPO_MEM_DEPTH];
   logic [ADCPO_PTR_W-1:0] wr_ff, nxt_wr, rdp_ff, nxt_rdp;
   logic [ADCPO_PTR_W:0] cnt_ff, nxt_cnt;
   logic rd_fall, store_push, store_pop, cycle_start;
   adcpo_word_s head_word;

   assign head_word = mem_ff[rdp_ff];
   assign rd_fall = rd_prev_ff && !rd_s;

   // direct mode pops only at the falling strobe; burst mode fills store
   assign buf_ready = (state_ff == ADCPO_ST_DIRECT) ? (timer_ff == 9'h000)
      : (state_ff == ADCPO_ST_RESTART) ? 1'b0
      : (cnt_ff != (ADCPO_PTR_W+1)'(ADCPO_MEM_DEPTH));

   always_comb begin
      nxt_state = state_ff;
      nxt_timer = timer_ff;
      nxt_ready = ready_ff;
      nxt_dout = dout_ff;
      nxt_ovr = ovr_ff;
      nxt_settle = settle_ff;
      nxt_settled = settled_ff;
      nxt_rd_prev = rd_prev_ff;
      nxt_avail = avail_ff;
      nxt_mem = mem_ff;
      nxt_wr = wr_ff;
      nxt_rdp = rdp_ff;
      nxt_cnt = cnt_ff;
      nxt_oe = oe_ff;
      store_push = 1'b0;
      store_pop = 1'b0;
      cycle_start = 1'b0;
      if (run) begin
         nxt_oe = !rd_s && !cs_s;
         nxt_rd_prev = rd_s;
         nxt_timer = timer_ff + 9'h001;
         case (state_ff)
            ADCPO_ST_RESTART: begin
               // wait out the pin syncs so their reset values pick no mode
               nxt_ready = 1'b1;
               nxt_cnt = '0;
               nxt_wr = '0;
               nxt_rdp = '0;
               nxt_avail = 4'h0;
               if (timer_ff >= ADCPO_SYNC_WAIT) begin
                  nxt_timer = 9'h000;
                  nxt_state = buf_en_s ? ADCPO_ST_FIRST : ADCPO_ST_DIRECT;
               end
            end
            ADCPO_ST_DIRECT: begin
               if (timer_ff == 9'h000) begin
                  nxt_ready = 1'b0;
                  cycle_start = 1'b1;
                  if (buf_valid) begin
                     nxt_dout = buf_word.data;
                     nxt_ovr = buf_word.ovr;
                  end
               end else if (timer_ff == ADCPO_HALF_T) begin
                  nxt_ready = 1'b1;
               end
               if (adcpo_last(timer_ff, 9'(ADCPO_DECIM))) begin
                  nxt_timer = 9'h000;
               end
               if (buf_en_s) begin
                  nxt_state = ADCPO_ST_RESTART;
               end
            end
            ADCPO_ST_FIRST: begin
               if (adcpo_last(timer_ff, first_len)) begin
                  nxt_ready = 1'b0;
                  nxt_timer = 9'h000;
                  nxt_avail = readings_per_burst;
                  cycle_start = 1'b1;
                  nxt_state = ADCPO_ST_BURST;
               end
            end
            ADCPO_ST_BURST: begin
               nxt_ready = 1'b0;
               if (adcpo_last(timer_ff, burst_len)) begin
                  nxt_ready = 1'b1;
                  nxt_timer = 9'h000;
                  nxt_avail = readings_per_burst;
                  cycle_start = 1'b1;
               end
            end
            default: begin
               nxt_state = ADCPO_ST_RESTART;
            end
         endcase
         if ((state_ff == ADCPO_ST_FIRST || state_ff == ADCPO_ST_BURST)
             && !buf_en_s) begin
            nxt_state = ADCPO_ST_RESTART;
         end
         // burst store: fill from the buffer, drain one per read pulse
         if (state_ff == ADCPO_ST_FIRST || state_ff == ADCPO_ST_BURST) begin
            store_push = buf_valid && buf_ready;
            store_pop = (state_ff == ADCPO_ST_BURST) && rd_fall
                        && avail_ff != 4'h0 && cnt_ff != '0;
            if (store_push) begin
               nxt_mem[wr_ff] = buf_word;
               nxt_wr = wr_ff + 1'b1;
            end
            if (store_pop) begin
               nxt_dout = head_word.data;
               nxt_ovr = head_word.ovr;
               nxt_rdp = rdp_ff + 1'b1;
               if (!adcpo_last(timer_ff, burst_len)) begin
                  nxt_avail = avail_ff - 4'h1;
               end
            end
            if (store_push && !store_pop) begin
               nxt_cnt = cnt_ff + 1'b1;
            end else if (store_pop && !store_push) begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         // early words are flagged unsettled until enough strobe cycles
         if (cycle_start && !settled_ff) begin
            nxt_settle = settle_ff + 6'h01;
            nxt_settled = (settle_ff + 6'h01) == ADCPO_SETTLE_T;
         end
      end else if (!pd_s) begin
         nxt_oe = 1'b0;
      end
   end

   // the reset pin forces the strobe high and the bus low at once
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         state_ff <= ADCPO_ST_RESTART;
         timer_ff <= 9'h000;
         ready_ff <= 1'b1;
         dout_ff <= ADCPO_DOUT_RST;
         ovr_ff <= 1'b0;
         oe_ff <= 1'b0;
         settle_ff <= 6'h00;
         settled_ff <= 1'b0;
         rd_prev_ff <= 1'b1;
         avail_ff <= 4'h0;
         for (int i = 0; i < ADCPO_MEM_DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
         wr_ff <= '0;
         rdp_ff <= '0;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
         ready_ff <= nxt_ready;
         dout_ff <= nxt_dout;
         ovr_ff <= nxt_ovr;
         oe_ff <= nxt_oe;
         settle_ff <= nxt_settle;
         settled_ff <= nxt_settled;
         rd_prev_ff <= nxt_rd_prev;
         avail_ff <= nxt_avail;
         mem_ff <= nxt_mem;
         wr_ff <= nxt_wr;
         rdp_ff <= nxt_rdp;
         cnt_ff <= nxt_cnt;
      end
   end

   assign SAMPLE_READY_N = ready_ff;
   assign DOUT_O = dout_ff;
   assign DOUT_OE = oe_ff;
   assign OVER_RANGE_FLAG = ovr_ff;
   assign DATA_SETTLED = settled_ff;

   // helper: length of the current low phase of the strobe
   logic [8:0] low_len_ff;
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         low_len_ff <= 9'h000;
      end else if (run) begin
         low_len_ff <= ready_ff ? 9'h000 : low_len_ff + 9'h001;
      end
   end

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   AST_OE_ON: assert property (run && !rd_s && !cs_s |=> DOUT_OE)
      else $error("bus not driven with read and select low");
   AST_OE_OFF: assert property (run && (rd_s || cs_s) |=> !DOUT_OE)
      else $error("bus driven with read or select high");
   AST_LOW16: assert property (run && ready_ff == 1'b0
      && state_ff == ADCPO_ST_DIRECT && timer_ff == ADCPO_HALF_T
      |-> low_len_ff == ADCPO_HALF_T - 9'h001)
      else $error("direct low phase not 16 clocks");
   AST_DOUT_AT_FALL: assert property (run
      && state_ff == ADCPO_ST_DIRECT && timer_ff == 9'h000 && buf_valid
      |=> !SAMPLE_READY_N && DOUT_O == $past(buf_word.data))
      else $error("word not loaded at ready fall");
   AST_PULSE1: assert property (run && state_ff == ADCPO_ST_BURST
      && ready_ff ##1 run |-> !ready_ff)
      else $error("burst ready pulse longer than one clock");
   AST_PERIOD: assert property (run && state_ff == ADCPO_ST_BURST
      && buf_en_s && timer_ff == burst_len - 9'h001
      |=> SAMPLE_READY_N && timer_ff == 9'h000)
      else $error("burst period end missed");
   AST_FIRST: assert property (run && state_ff == ADCPO_ST_FIRST
      && buf_en_s && timer_ff == first_len - 9'h001
      |=> !SAMPLE_READY_N && state_ff == ADCPO_ST_BURST)
      else $error("first ready low at wrong time");
   AST_READ: assert property (run && state_ff == ADCPO_ST_BURST
      && buf_en_s && rd_fall && avail_ff != 4'h0 && cnt_ff != '0
      |=> DOUT_O == $past(head_word.data))
      else $error("read pulse did not deliver next reading");
   AST_SETTLE: assert property (
      DATA_SETTLED |-> settle_ff == ADCPO_SETTLE_T)
      else $error("settled before 46 ready cycles");
   AST_PD: assert property (CLK_EN && !pd_s
      |=> !DOUT_OE && $stable(dout_ff) && $stable(timer_ff))
      else $error("power down did not freeze the port");
endmodule : adcpo_top

// ---- testbench/adcpo_host_model.sv ----
// host side model: drives read and chip select, collects bus words
`timescale 1ns/10ps
module adcpo_host_model
   import adcpo_pkg::*;
(
   input wire logic clk,
   input wire logic [ADCPO_RES_W-1:0] dout,
   input wire logic dout_oe,
   output logic rd_n,
   output logic cs_n
);
   initial begin
      rd_n = 1'b1;
      cs_n = 1'b1;
   end

   // park both strobes at given levels, changed just after an edge
   task automatic set_pins(input logic rd, input logic cs);
      @(posedge clk);
      #2;
      cs_n = cs;
      rd_n = rd;
   endtask : set_pins

   // one read pulse; phases stay several clocks so the pin syncs see them
   task automatic read_once(input int low_cyc,
                            output logic [ADCPO_RES_W-1:0] word,
                            output logic oe);
      @(posedge clk);
      #2 cs_n = 1'b0;
      @(posedge clk);
      #2 rd_n = 1'b0;
      repeat (low_cyc) @(posedge clk);
      #2;
      word = dout;
      oe = dout_oe;
      rd_n = 1'b1;
      @(posedge clk);
      #2 cs_n = 1'b1;
      repeat (2) @(posedge clk);
   endtask : read_once
endmodule : adcpo_host_model

// ---- testbench/tb_adcpo_top.sv ----
// self-checking bench for the parallel result port
`timescale 1ns/10ps
module tb_adcpo_top
   import adcpo_pkg::*;
;
   logic clk;
   logic resetn = 1'b0;
   logic mod_bit = 1'b1;
   logic pd_n = 1'b1;
   logic clk_en = 1'b1;
   logic buf_en = 1'b0;
   logic [2:0] sel = 3'h0;
   logic rd_n;
   logic cs_n;
   logic ready_n;
   logic [ADCPO_RES_W-1:0] dout;
   logic oe;
   logic ovr;
   logic settled;
   int pat = 0;
   int cyc = 0;
   int err_total = 0;
   int checks_done = 0;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // modulator stream: 0 all ones, 1 all zeros, 2 alternating
   always @(posedge clk) begin
      #2;
      mod_bit = (pat == 2) ? ~mod_bit : (pat == 0);
      cyc++;
   end

   adcpo_top dut (.CLK_SYS(clk), .RESETN(resetn), .CLK_EN(clk_en),
      .MOD_BIT(mod_bit), .POWERDOWN_N(pd_n), .BUFFER_EN(buf_en),
      .BUFFER_DEPTH_SEL(sel), .RD_N(rd_n), .CS_N(cs_n),
      .SAMPLE_READY_N(ready_n), .DOUT_O(dout), .DOUT_OE(oe),
      .OVER_RANGE_FLAG(ovr), .DATA_SETTLED(settled));

   adcpo_host_model host (.clk(clk), .dout(dout), .dout_oe(oe),
      .rd_n(rd_n), .cs_n(cs_n));

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [17:0] seen,
                        input logic [17:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // count clocks until the ready strobe shows the wanted level
   task automatic wait_ready(input logic lvl, output int n);
      n = 0;
      while (ready_n !== lvl) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 2000) begin
            err_total++;
            end_of_test();
         end
      end
   endtask : wait_ready

   // reset held six clocks, outputs looked at while it is held
   task automatic do_reset;
      resetn = 1'b0;
      repeat (6) @(posedge clk);
      #2;
      check("ready in reset", 18'(ready_n), 18'h00001);
      check("bus in reset", dout, 18'h00000);
      resetn = 1'b1;
   endtask : do_reset

   // direct mode: codes for full scale both ways and mid scale, phases
   task automatic t_direct;
      int n;
      logic [17:0] exp [3] = '{18'h1FFFF, 18'h20000, 18'h00000};
      buf_en = 1'b0;
      do_reset();
      for (int p = 0; p < 3; p++) begin
         pat = p;
         repeat (4) begin
            wait_ready(1'b0, n);
            wait_ready(1'b1, n);
         end
         wait_ready(1'b0, n);
         check("direct word", dout, exp[p]);
         check("over range", 18'(ovr), (p < 2) ? 18'h1 : 18'h0);
         wait_ready(1'b1, n);
         check("low phase", 18'(n), 18'h00010);
         wait_ready(1'b0, n);
         check("high phase", 18'(n), 18'h00010);
      end
   endtask : t_direct

   // settled flag only after 46 strobe cycles from reset
   task automatic t_settle;
      int n;
      do_reset();
      repeat (45) begin
         wait_ready(1'b0, n);
         wait_ready(1'b1, n);
      end
      check("settled early", 18'(settled), 18'h00000);
      wait_ready(1'b0, n);
      wait_ready(1'b1, n);
      check("settled", 18'(settled), 18'h00001);
   endtask : t_settle

   // bus drive only with both strobes low; power down drops it
   task automatic t_bus;
      logic r;
      host.set_pins(1'b0, 1'b1);
      repeat (5) @(posedge clk);
      #2;
      check("oe cs high", 18'(oe), 18'h00000);
      host.set_pins(1'b0, 1'b0);
      repeat (5) @(posedge clk);
      #2;
      check("oe both low", 18'(oe), 18'h00001);
      pd_n = 1'b0;
      repeat (5) @(posedge clk);
      #2;
      check("oe power down", 18'(oe), 18'h00000);
      pd_n = 1'b1;
      host.set_pins(1'b1, 1'b0);
      repeat (5) @(posedge clk);
      #2;
      check("oe rd high", 18'(oe), 18'h00000);
      host.set_pins(1'b1, 1'b1);
      // 16 enabled clocks would always flip the strobe; disabled ones not
      r = ready_n;
      clk_en = 1'b0;
      repeat (16) @(posedge clk);
      #2;
      check("frozen ready", 18'(ready_n), 18'(r));
      clk_en = 1'b1;
   endtask : t_bus

   // burst mode at one level: start delay, pulse width, reads, period
   task automatic t_burst(input logic [2:0] s);
      int n;
      int t0;
      int lv;
      logic [17:0] w;
      logic e;
      lv = int'(s) + 1;
      buf_en = 1'b1;
      sel = s;
      pat = 0;
      do_reset();
      t0 = cyc;
      // no false strobe while the mode pin crosses its syncs
      repeat (6) begin
         @(posedge clk);
         #1;
         check("ready after reset", 18'(ready_n), 18'h00001);
      end
      wait_ready(1'b1, n);
      wait_ready(1'b0, n);
      n = cyc - t0;
      check("first low", 18'(n >= 32 * (lv + 1) && n <= 32 * (lv + 1) + 6),
            18'h00001);
      wait_ready(1'b1, n);
      wait_ready(1'b0, n);
      check("pulse width", 18'(n), 18'h00001);
      t0 = cyc;
      // host reads only after ready is low and the first pulse is past
      repeat (lv) begin
         host.read_once(6, w, e);
         check("burst word", w, 18'h1FFFF);
         check("burst oe", 18'(e), 18'h00001);
      end
      wait_ready(1'b1, n);
      wait_ready(1'b0, n);
      check("burst period", 18'(cyc - t0), 18'(32 * lv));
   endtask : t_burst

   initial begin
      t_direct();
      t_settle();
      t_bus();
      t_burst(3'h0);
      t_burst(3'h2);
      t_burst(3'h7);
      end_of_test();
   end
endmodule : tb_adcpo_top
